/* File: rtl/rps_sequencer.sv */
// readback probe sequencer: target clock control, start conditions and snapshot timing
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - old targets: clock stopped throughout each readback
// - edge mode: trigger rising edge starts sequence
// - pre-count clocks first, between-count between snapshots
// - no edge before timeout: abandon, no readback
// - internal generator has selectable speed settings
// - every target clock leaves on clock pin
// - count N gives N consecutive snapshots
// - clock source: board clock or internal generator
// - stop clock, exact single pulses, resume
// - reset option resets target before first readback
// - manual mode waits for host keypress
// - one clock after acknowledged start edge
// - immediate mode starts at once on request
// - no counts programmed: no extra clocks
// - three start modes, any clock source
// - request out and data in reach target
module rps_sequencer #(
    parameter int unsigned SEC_CYCLES = rps_pkg::SEC_CYCLES,
    parameter int unsigned REQ_CYCLES = 8,
    parameter int unsigned BIT_CYCLES = 4,
    parameter int unsigned RB_BITS = 32,
    parameter int unsigned RST_CYCLES = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic board_clock_in,
    input wire logic trigger_in,
    input wire logic readback_data_in,
    output logic target_clock_out,
    output logic cable_request_out,
    output logic target_reset_out,
    output logic irq
);
    // registers
    rps_pkg::rps_ctrl_t ctrl_ff;
    logic [15:0] pre_ff, gap_ff;
    logic [7:0] tmo_ff;
    logic [7:0] snaps_ff;
    localparam int IRQ_W_L = rps_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] istat_ff, imask_ff;
    logic [31:0] rbdata_ff;
    // bus state
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    // pin synchronisers
    logic bclk_s1_ff, bclk_s2_ff;
    logic trig_s1_ff, trig_s2_ff, trig_d_ff;
    logic rd_s1_ff, rd_s2_ff;
    // clock generation
    logic [15:0] div_ff;
    logic isrc_ff;
    logic src_d_ff;
    logic tclk_ff;
    logic run_ff;
    logic [15:0] pend_ff;
    // sequencer
    rps_pkg::rps_state_t state_ff;
    logic [31:0] cnt_ff;
    logic [7:0] left_ff;
    logic [7:0] done_ff;
    logic [31:0] sec_ff;
    logic [7:0] secs_ff;
    logic req_ff, trst_ff;
    logic [IRQ_W_L-1:0] ev;

    // bus decode
    logic addr_ok;
    logic wr_now;
    logic [31:0] cmd;
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_now = wr_pend_ff;
    assign cmd = (wr_now && wr_addr_ff == rps_pkg::OFS_CMD) ? hwdata : 32'h0000_0000;

    // address phase: single-cycle slave, writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    // read mux captured in address phase, hrdata from a flop
    logic [31:0] rd_mux;
    always_comb begin
        case (haddr[7:0])
            rps_pkg::OFS_CTRL: rd_mux = {25'h0, ctrl_ff};
            rps_pkg::OFS_PRE: rd_mux = {16'h0, pre_ff};
            rps_pkg::OFS_GAP: rd_mux = {16'h0, gap_ff};
            rps_pkg::OFS_TMO: rd_mux = {24'h0, tmo_ff};
            rps_pkg::OFS_SNAPS: rd_mux = {24'h0, snaps_ff};
            rps_pkg::OFS_PULSE: rd_mux = {16'h0, pend_ff};
            rps_pkg::OFS_STATUS: rd_mux = {8'h0, done_ff, 8'h0, 3'h0, tclk_ff, ~run_ff,
                state_ff};
            rps_pkg::OFS_IRQ_STAT: rd_mux = {28'h0, istat_ff};
            rps_pkg::OFS_IRQ_MASK: rd_mux = {28'h0, imask_ff};
            rps_pkg::OFS_RB_DATA: rd_mux = rbdata_ff;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0;
        end else if (addr_ok && !hwrite) begin
            hrdata_ff <= rd_mux;
        end
    end
    assign hrdata = hrdata_ff;

    // zero wait states, always OKAY, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // configuration registers; clock counts and timeout reset to zero so omitted ones mean none, snapshot count resets to one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= rps_pkg::CTRL_RST;
            pre_ff <= 16'h0000;
            gap_ff <= 16'h0000;
            tmo_ff <= 8'h00;
            snaps_ff <= 8'h01;
            imask_ff <= '0;
        end else if (wr_now) begin
            case (wr_addr_ff)
                rps_pkg::OFS_CTRL: ctrl_ff <= rps_pkg::rps_ctrl_t'(hwdata[6:0]);
                rps_pkg::OFS_PRE: pre_ff <= hwdata[15:0];
                rps_pkg::OFS_GAP: gap_ff <= hwdata[15:0];
                rps_pkg::OFS_TMO: tmo_ff <= hwdata[7:0];
                rps_pkg::OFS_SNAPS: snaps_ff <= hwdata[7:0];
                rps_pkg::OFS_IRQ_MASK: imask_ff <= hwdata[IRQ_W_L-1:0];
                default: ;
            endcase
        end
    end

    // sticky events; a new event wins over a write-one clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_ff <= '0;
        end else if (wr_now && wr_addr_ff == rps_pkg::OFS_IRQ_STAT) begin
            istat_ff <= (istat_ff & ~hwdata[IRQ_W_L-1:0]) | ev;
        end else begin
            istat_ff <= istat_ff | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_ff & imask_ff);
        end
    end

    // pin synchronisers; the first stage is never looked at
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_s1_ff <= 1'b0;
            bclk_s2_ff <= 1'b0;
            trig_s1_ff <= 1'b0;
            trig_s2_ff <= 1'b0;
            trig_d_ff <= 1'b0;
            rd_s1_ff <= 1'b0;
            rd_s2_ff <= 1'b0;
        end else begin
            bclk_s1_ff <= board_clock_in;
            bclk_s2_ff <= bclk_s1_ff;
            trig_s1_ff <= trigger_in;
            trig_s2_ff <= trig_s1_ff;
            trig_d_ff <= trig_s2_ff;
            rd_s1_ff <= readback_data_in;
            rd_s2_ff <= rd_s1_ff;
        end
    end

    logic trig_rise;
    assign trig_rise = trig_s2_ff && !trig_d_ff;

    // internal generator: speed picks the half period
    logic [15:0] half;
    always_comb begin
        case (ctrl_ff.speed)
            2'h0: half = rps_pkg::HALF0;
            2'h1: half = rps_pkg::HALF1;
            2'h2: half = rps_pkg::HALF2;
            default: half = rps_pkg::HALF3;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 16'h0000;
            isrc_ff <= 1'b0;
        end else if (div_ff >= half - 16'h0001) begin
            div_ff <= 16'h0000;
            isrc_ff <= ~isrc_ff;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    // chosen source level; board clock is only ever used after its synchroniser
    logic src;
    assign src = ctrl_ff.ext_src ? bclk_s2_ff : isrc_ff;

    // the target is held unless free-running and not in a static readback
    logic hold;
    logic free;
    assign hold = (state_ff != rps_pkg::S_IDLE) && !ctrl_ff.async_probe;
    assign free = run_ff && !hold;

    // pulses leave only on source rising edges, so counted pulses are whole
    logic src_rise;
    logic src_fall;
    assign src_rise = src && !src_d_ff;
    assign src_fall = !src && src_d_ff;

    logic seq_load;
    logic [15:0] seq_pulses;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_d_ff <= 1'b0;
            tclk_ff <= 1'b0;
            run_ff <= 1'b1;
            pend_ff <= 16'h0000;
        end else begin
            src_d_ff <= src;
            if (cmd[rps_pkg::CMD_STOP]) begin
                run_ff <= 1'b0;
            end else if (cmd[rps_pkg::CMD_RESUME]) begin
                run_ff <= 1'b1;
            end
            if (src_fall) begin
                tclk_ff <= 1'b0;
            end else if (src_rise && (free || pend_ff != 16'h0000)) begin
                tclk_ff <= 1'b1;
            end
            if (seq_load) begin
                pend_ff <= seq_pulses;
            end else if (wr_now && wr_addr_ff == rps_pkg::OFS_PULSE &&
                         state_ff == rps_pkg::S_IDLE && !free) begin
                pend_ff <= hwdata[15:0];
            end else if (src_rise && !free && pend_ff != 16'h0000) begin
                pend_ff <= pend_ff - 16'h0001;
            end
        end
    end
    assign target_clock_out = tclk_ff;

    // burst finished once every pulse has gone out and the clock is low again
    logic burst_done;
    assign burst_done = pend_ff == 16'h0 && !tclk_ff;

    // one-second prescaler for the start timeout
    logic sec_tick;
    assign sec_tick = sec_ff == 32'(SEC_CYCLES - 1);

    // sequence: start condition, reset, pre-count, snapshots with gaps
    logic start;
    assign start = cmd[rps_pkg::CMD_START] && state_ff == rps_pkg::S_IDLE && snaps_ff != 8'h00;
    logic pulse_was_busy_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= rps_pkg::S_IDLE;
            cnt_ff <= 32'h0;
            left_ff <= 8'h00;
            done_ff <= 8'h00;
            sec_ff <= 32'h0;
            secs_ff <= 8'h00;
            req_ff <= 1'b0;
            trst_ff <= 1'b0;
            rbdata_ff <= 32'h0;
        end else if (cmd[rps_pkg::CMD_ABORT]) begin
            state_ff <= rps_pkg::S_IDLE;
            req_ff <= 1'b0;
            trst_ff <= 1'b0;
        end else begin
            case (state_ff)
                rps_pkg::S_IDLE: begin
                    if (start) begin
                        left_ff <= snaps_ff;
                        done_ff <= 8'h00;
                        sec_ff <= 32'h0;
                        secs_ff <= 8'h00;
                        cnt_ff <= 32'h0;
                        if (ctrl_ff.trig == rps_pkg::TRIG_NONE) begin
                            state_ff <= rps_pkg::S_RST;
                        end else begin
                            state_ff <= rps_pkg::S_WAIT;
                        end
                    end
                end
                rps_pkg::S_WAIT: begin
                    sec_ff <= sec_tick ? 32'h0 : sec_ff + 32'h1;
                    if (sec_tick) begin
                        secs_ff <= secs_ff + 8'h01;
                    end
                    if (ctrl_ff.trig == rps_pkg::TRIG_AUTO && trig_rise) begin
                        state_ff <= rps_pkg::S_ACK;
                    end else if (ctrl_ff.trig == rps_pkg::TRIG_MANUAL &&
                                 cmd[rps_pkg::CMD_KEY]) begin
                        state_ff <= rps_pkg::S_RST;
                    end else if (ctrl_ff.trig == rps_pkg::TRIG_AUTO && tmo_ff != 8'h00 &&
                                 sec_tick && secs_ff + 8'h01 >= tmo_ff) begin
                        state_ff <= rps_pkg::S_IDLE;
                    end
                end
                rps_pkg::S_ACK: begin
                    if (burst_done && cnt_ff != 32'h0) begin
                        cnt_ff <= 32'h0;
                        state_ff <= rps_pkg::S_RST;
                    end else begin
                        cnt_ff <= 32'h1;
                    end
                end
                rps_pkg::S_RST: begin
                    if (!ctrl_ff.reset_opt || cnt_ff == 32'(RST_CYCLES)) begin
                        trst_ff <= 1'b0;
                        cnt_ff <= 32'h0;
                        state_ff <= rps_pkg::S_PRE;
                    end else begin
                        trst_ff <= 1'b1;
                        cnt_ff <= cnt_ff + 32'h1;
                    end
                end
                rps_pkg::S_PRE, rps_pkg::S_GAP: begin
                    if (burst_done && cnt_ff != 32'h0) begin
                        cnt_ff <= 32'h0;
                        state_ff <= rps_pkg::S_REQ;
                    end else begin
                        cnt_ff <= 32'h1;
                    end
                end
                rps_pkg::S_REQ: begin
                    if (cnt_ff == 32'(REQ_CYCLES)) begin
                        req_ff <= 1'b0;
                        cnt_ff <= 32'h0;
                        state_ff <= rps_pkg::S_SHIFT;
                    end else begin
                        req_ff <= 1'b1;
                        cnt_ff <= cnt_ff + 32'h1;
                    end
                end
                rps_pkg::S_SHIFT: begin
                    cnt_ff <= cnt_ff + 32'h1;
                    if (cnt_ff % 32'(BIT_CYCLES) == 32'(BIT_CYCLES - 1)) begin
                        rbdata_ff <= {rbdata_ff[30:0], rd_s2_ff};
                    end
                    if (cnt_ff == 32'(RB_BITS * BIT_CYCLES - 1)) begin
                        cnt_ff <= 32'h0000_0000;
                        done_ff <= done_ff + 8'h01;
                        left_ff <= left_ff - 8'h01;
                        state_ff <= (left_ff == 8'h01) ? rps_pkg::S_IDLE : rps_pkg::S_GAP;
                    end
                end
                default: state_ff <= rps_pkg::S_IDLE;
            endcase
        end
    end
    assign cable_request_out = req_ff;
    assign target_reset_out = trst_ff;

    // burst loads on entry to each clocking state; zero counts give no clocks
    always_comb begin
        seq_load = 1'b0;
        seq_pulses = 16'h0;
        if (cnt_ff == 32'h0000_0000) begin
            case (state_ff)
                rps_pkg::S_ACK: begin
                    seq_load = 1'b1;
                    seq_pulses = 16'h0001;
                end
                rps_pkg::S_PRE: begin
                    seq_load = 1'b1;
                    seq_pulses = pre_ff;
                end
                rps_pkg::S_GAP: begin
                    seq_load = 1'b1;
                    seq_pulses = gap_ff;
                end
                default: ;
            endcase
        end
    end

    // events feeding the sticky status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_was_busy_ff <= 1'b0;
        end else begin
            pulse_was_busy_ff <= state_ff == rps_pkg::S_IDLE && pend_ff != 16'h0000;
        end
    end

    always_comb begin
        ev = '0;
        ev[rps_pkg::IRQ_DONE] = state_ff == rps_pkg::S_SHIFT && left_ff == 8'h01 &&
            cnt_ff == 32'(RB_BITS * BIT_CYCLES - 1);
        ev[rps_pkg::IRQ_TIMEOUT] = state_ff == rps_pkg::S_WAIT &&
            ctrl_ff.trig == rps_pkg::TRIG_AUTO && !trig_rise && tmo_ff != 8'h00 &&
            sec_tick && secs_ff + 8'h01 >= tmo_ff;
        ev[rps_pkg::IRQ_SNAP] = state_ff == rps_pkg::S_SHIFT &&
            cnt_ff == 32'(RB_BITS * BIT_CYCLES - 1);
        ev[rps_pkg::IRQ_PULSES] = pulse_was_busy_ff && pend_ff == 16'h0000 &&
            state_ff == rps_pkg::S_IDLE;
    end

    // hsize is accepted as-is: only whole-word transfers are used
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8]};
endmodule : rps_sequencer
`default_nettype wire

/* File: include/rps_pkg.sv */
// shared constants and types of the readback probe sequencer
package rps_pkg;
    // system clock
    localparam int unsigned CLK_HZ = 125_000_000;
    // internal generator speed settings, figures in hertz
    localparam int unsigned SPD0_HZ = 460_800;
    localparam int unsigned SPD1_HZ = 921_000;
    localparam int unsigned SPD2_HZ = 1_843_200;
    localparam int unsigned SPD3_HZ = 2_750_000;
    // half periods of the generated target clock in system cycles (rounded down)
    localparam logic [15:0] HALF0 = 16'(CLK_HZ / (2 * SPD0_HZ));
    localparam logic [15:0] HALF1 = 16'(CLK_HZ / (2 * SPD1_HZ));
    localparam logic [15:0] HALF2 = 16'(CLK_HZ / (2 * SPD2_HZ));
    localparam logic [15:0] HALF3 = 16'(CLK_HZ / (2 * SPD3_HZ));
    // one second of wait, in system cycles
    localparam int unsigned SECOND_S = 1;
    localparam int unsigned SEC_CYCLES = SECOND_S * CLK_HZ;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRE = 8'h04;
    localparam logic [7:0] OFS_GAP = 8'h08;
    localparam logic [7:0] OFS_TMO = 8'h0C;
    localparam logic [7:0] OFS_SNAPS = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_PULSE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_RB_DATA = 8'h28;

    // command register bits
    localparam int CMD_START = 0;
    localparam int CMD_KEY = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_RESUME = 3;
    localparam int CMD_ABORT = 4;

    // interrupt status bits
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_SNAP = 2;
    localparam int IRQ_PULSES = 3;

    // start condition modes
    localparam logic [1:0] TRIG_MANUAL = 2'h0;
    localparam logic [1:0] TRIG_NONE = 2'h1;
    localparam logic [1:0] TRIG_AUTO = 2'h2;

    // control register layout, reset value all zero
    typedef struct packed {
        logic async_probe; // [6] keep the target clock running during readback
        logic reset_opt;   // [5] reset the target before the first readback
        logic [1:0] trig;  // [4:3] start condition mode
        logic ext_src;     // [2] 1: board clock, 0: internal generator
        logic [1:0] speed; // [1:0] internal generator setting
    } rps_ctrl_t;
    localparam rps_ctrl_t CTRL_RST = '0;

    // sequence states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WAIT = 3'b001,
        S_ACK = 3'b010,
        S_RST = 3'b011,
        S_PRE = 3'b100,
        S_REQ = 3'b101,
        S_SHIFT = 3'b110,
        S_GAP = 3'b111
    } rps_state_t;
endpackage : rps_pkg

/* File: tb/rps_target_model.sv */
// behavioural target: counts clocks, latches snapshots
`timescale 1ns/1ps
`default_nettype none
module rps_target_model (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic rst_in,
    output wire logic data_out
);
    int clocks = 0;
    int snaps = 0;
    // steps on each clock, cleared by reset
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) clocks <= 0;
        else clocks <= clocks + 1;
    end
    // latches state on request rising edge
    always @(posedge req_in) begin
        snaps <= snaps + 1;
    end
    // alternates per snapshot so stale data shows
    assign data_out = snaps[0];
endmodule : rps_target_model
`default_nettype wire

/* File: tb/rps_sequencer_properties.sv */
// concurrent checks of the sequencer's bus and target pins
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer_properties #(
    parameter int unsigned REQ_CYCLES = 8,
    parameter int unsigned BIT_CYCLES = 4,
    parameter int unsigned RB_BITS = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic target_clock_out,
    input wire logic cable_request_out,
    input wire logic target_reset_out
);
    logic req_q_ff;
    logic [15:0] quiet_ff;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // request plus shift span: target clock frozen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q_ff <= 1'b0;
            quiet_ff <= 16'h0000;
        end else begin
            req_q_ff <= cable_request_out;
            if (cable_request_out && !req_q_ff) begin
                quiet_ff <= 16'(REQ_CYCLES + RB_BITS * BIT_CYCLES - 1);
            end else if (quiet_ff != 16'h0000) begin
                quiet_ff <= quiet_ff - 16'h0001;
            end
        end
    end
    bus_ready_a: assert property (hreadyout) else $error("wait state inserted");
    bus_okay_a: assert property (!hresp) else $error("error response seen");
    req_width_a: assert property (
        $rose(cable_request_out) |-> cable_request_out[*8] ##1 !cable_request_out)
        else $error("bad request width");
    shift_quiet_a: assert property (
        quiet_ff != 16'h0000 |-> $stable(target_clock_out))
        else $error("target clock moved during readback");
    rst_width_a: assert property (
        $rose(target_reset_out) |-> target_reset_out[*8] ##9 !target_reset_out)
        else $error("bad reset width");
    rst_no_req_a: assert property (
        target_reset_out |-> !cable_request_out) else $error("request during reset");
    rdata_hold_a: assert property (
        !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("hrdata changed");
    unmapped_zero_a: assert property (
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] > rps_pkg::OFS_RB_DATA
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    cover property ($rose(cable_request_out));
    cover property ($rose(target_reset_out));
    cover property (quiet_ff == 16'h0001);
endmodule : rps_sequencer_properties
bind rps_sequencer rps_sequencer_properties #(.REQ_CYCLES(REQ_CYCLES),
    .BIT_CYCLES(BIT_CYCLES), .RB_BITS(RB_BITS)) i_rps_sequencer_properties (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .target_clock_out,
    .cable_request_out, .target_reset_out);
`default_nettype wire

/* File: tb/rps_sequencer_tb_top.sv */
// self-checking bench for the readback probe sequencer
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lfsr = 32'h7716;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, board_clock_in = 1'b0, trigger_in = 1'b0, rb_data;
    logic target_clock_out, cable_request_out, target_reset_out, irq;
    logic clk_q = 1'b0, req_q = 1'b0, rst_q = 1'b0;
    int error_cnt = 0, cmp_count = 0, edges = 0, nreq = 0, nrst = 0;
    int q[$];
    always #4 hclk = ~hclk;
    // board clock unrelated to the generator
    always begin
        repeat (3) @(posedge hclk);
        board_clock_in <= ~board_clock_in;
    end
    rps_sequencer #(.SEC_CYCLES(100)) i_rps_sequencer (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .board_clock_in, .trigger_in, .readback_data_in(rb_data), .target_clock_out,
        .cable_request_out, .target_reset_out, .irq);
    rps_target_model i_rps_target_model (.clk_in(target_clock_out),
        .req_in(cable_request_out), .rst_in(target_reset_out), .data_out(rb_data));
    // pin monitor at falling edge
    always @(negedge hclk) begin
        if (target_clock_out && !clk_q) edges++;
        if (cable_request_out && !req_q) begin
            q.push_back(edges);
            edges = 0;
            nreq++;
        end
        if (target_reset_out && !rst_q) nrst++;
        clk_q = target_clock_out;
        req_q = cable_request_out;
        rst_q = target_reset_out;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // single transfer, each phase held until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        bus(1'b0, a, 32'h0, x);
    endtask : rd
    task automatic wait_irq();
        for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge hclk);
    endtask : wait_irq
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    // one request, clock stopped
    task automatic run(input logic [1:0] trig, input int pre, input int gap, input int sn);
        logic [31:0] x;
        wr(rps_pkg::OFS_CMD, 32'h4);
        wr(rps_pkg::OFS_CTRL, {27'h1, trig, 3'h3});
        wr(rps_pkg::OFS_PRE, 32'(pre));
        wr(rps_pkg::OFS_GAP, 32'(gap));
        wr(rps_pkg::OFS_SNAPS, 32'(sn));
        wr(rps_pkg::OFS_IRQ_MASK, 32'h1);
        repeat (60) @(posedge hclk);
        q.delete();
        nrst = 0;
        edges = 0;
        wr(rps_pkg::OFS_CMD, 32'h1);
        repeat (40) @(posedge hclk);
        if (trig != rps_pkg::TRIG_NONE) begin
            check(q.size(), 0);
            if (trig == rps_pkg::TRIG_AUTO) trigger_in <= 1'b1;
            else wr(rps_pkg::OFS_CMD, 32'h2);
        end
        wait_irq();
        trigger_in <= 1'b0;
        check(q.size(), sn);
        check(nrst, 1);
        check(q[0], pre + int'(trig == rps_pkg::TRIG_AUTO));
        for (int i = 1; i < sn; i++) check(q[i], gap);
        rd(rps_pkg::OFS_RB_DATA, x);
        check(x, {32{nreq[0]}});
        wr(rps_pkg::OFS_IRQ_STAT, 32'hF);
        repeat (3) @(posedge hclk);
        check(irq, 1'b0);
    endtask : run
    initial begin
        logic [31:0] x;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(rps_pkg::OFS_CTRL, x);
        check(x, 32'h0);
        rd(rps_pkg::OFS_SNAPS, x);
        check(x, 32'h1);
        rd(8'h40, x);
        check(x, 32'h0);
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            run((k == 3) ? rps_pkg::TRIG_AUTO : 2'(k), (k == 3) ? 0 : int'(lfsr[1:0]),
                (k == 3) ? 0 : int'(lfsr[3:2]) % 3, 1 + int'(lfsr[5:4]) % 3);
            $display("sequence test %0d done", k);
        end
        // no trigger edge: the request must lapse with nothing read
        wr(rps_pkg::OFS_CTRL, {27'h0, rps_pkg::TRIG_AUTO, 3'h3});
        wr(rps_pkg::OFS_TMO, 32'h1);
        wr(rps_pkg::OFS_IRQ_MASK, 32'h2);
        q.delete();
        wr(rps_pkg::OFS_CMD, 32'h1);
        wait_irq();
        check(irq, 1'b1);
        check(q.size(), 0);
        wr(rps_pkg::OFS_IRQ_STAT, 32'hF);
        $display("timeout test done");
        // single-step bursts from the board clock, then free run at speeds 1 and 3
        wr(rps_pkg::OFS_CTRL, 32'h4);
        wr(rps_pkg::OFS_IRQ_MASK, 32'h8);
        for (int n = 1; n <= 10; n += 9) begin
            edges = 0;
            wr(rps_pkg::OFS_PULSE, 32'(n));
            wait_irq();
            check(edges, n);
            wr(rps_pkg::OFS_IRQ_STAT, 32'hF);
        end
        wr(rps_pkg::OFS_CMD, 32'h8);
        for (int s = 1; s <= 3; s += 2) begin
            wr(rps_pkg::OFS_CTRL, 32'(s));
            edges = 0;
            repeat (1000) @(posedge hclk);
            x = 1000 / (2 * ((s == 1) ? rps_pkg::HALF1 : rps_pkg::HALF3));
            check(edges >= int'(x) - 1 && edges <= int'(x) + 1, 1'b1);
        end
        $display("clock test done");
        conclude();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        error_cnt++;
        conclude();
    end
endmodule : rps_sequencer_tb_top
`default_nettype wire
